// ---- seq_ctrl_pkg.sv ----
// Package: register map, limits and constants of the sequencer control
package seq_ctrl_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] CTRL_OFS = 12'h0000;
    localparam logic [11:0] GLIDE_OFS = 12'h0004;
    localparam logic [11:0] CHAIN_OFS = 12'h0008;
    localparam logic [11:0] STEP_OFS = 12'h000C;
    localparam logic [11:0] PITCH_OFS = 12'h0010;
    localparam logic [11:0] STATUS_OFS = 12'h0014;
    localparam logic [11:0] CAL_OFS = 12'h0018;
    localparam logic [11:0] SET_OFS = 12'h001C;
    localparam logic [11:0] OUT_OFS = 12'h0020;
    localparam logic [11:0] PATCH_OFS = 12'h0024;
    // ------------------------------------------------------------------
    // Values and limits
    // ------------------------------------------------------------------
    localparam logic [8:0] GLIDE_MAX = 9'h190;
    localparam logic [8:0] GLIDE_RST = 9'h000;
    localparam logic [8:0] PCT_FULL = 9'h064;
    localparam logic [6:0] CHAIN_MAX = 7'h63;
    localparam logic [6:0] CHAIN_RST = 7'h00;
    localparam logic [6:0] PATCH_CNT = 7'h63;
    localparam logic [3:0] LAST_STEP = 4'hF;
    localparam logic [3:0] OCT_CNT = 4'h8;
    localparam logic [15:0] UNITS_PER_VOLT = 16'h01F4;
    localparam logic [3:0] BRIGHT_RST = 4'hF;
    localparam logic [11:0] CHROMATIC = 12'hFFF;
    localparam int SCALE_NUM = 10;
    typedef enum logic [1:0] {
        MODE_SEQ = 2'b00,
        MODE_CAL = 2'b01
    } mode_t;
endpackage

// ---- seq_ctrl.sv ----
// Sequencer control: glide, scale quantizer, song chaining, calibration
`timescale 1ns/1ps
module seq_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Panel and jacks
    input wire logic shift_btn,
    input wire logic play_btn,
    input wire logic load_btn,
    input wire logic save_btn,
    input wire logic [15:0] step_btn,
    input wire logic enc_up,
    input wire logic enc_dn,
    input wire logic cv_up,
    input wire logic cv_dn,
    input wire logic clk_in,
    input wire logic reset_in,
    // Outputs
    output logic [15:0] pitch_out,
    output logic [15:0] cv_out,
    output logic [3:0] step_idx,
    output logic load_req,
    output logic [6:0] load_patch,
    output logic cal_store,
    output logic mutate_trig,
    output logic [3:0] brightness,
    output logic enc_invert,
    output logic numeric_disp,
    output logic chain_sel_loops
);
    // ------------------------------------------------------------------
    // Input synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [12:0] raw;
    logic [12:0] s1_q;
    logic [12:0] s2_q;
    logic [12:0] s3_q;
    logic [12:0] rise;
    assign raw = {reset_in, clk_in, cv_dn, cv_up, enc_dn, enc_up, save_btn,
                  load_btn, play_btn, shift_btn, step_btn[15],
                  step_btn[8], step_btn[10]};
    logic [15:0] st1_q;
    logic [15:0] st2_q;
    logic [15:0] st3_q;
    logic [15:0] step_rise;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_q <= 13'h0000;
            s2_q <= 13'h0000;
            s3_q <= 13'h0000;
            st1_q <= 16'h0000;
            st2_q <= 16'h0000;
            st3_q <= 16'h0000;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            st1_q <= step_btn;
            st2_q <= st1_q;
            st3_q <= st2_q;
        end
    end
    assign rise = s2_q & ~s3_q;
    assign step_rise = st2_q & ~st3_q;
    logic shift_lvl;
    logic shift_rise;
    logic play_rise;
    logic load_rise;
    logic save_rise;
    logic enc_inc;
    logic enc_dec;
    logic cv_inc;
    logic cv_dec;
    logic clk_rise;
    logic rst_rise;
    assign shift_lvl = s2_q[3];
    assign shift_rise = rise[3];
    assign play_rise = rise[4];
    assign load_rise = rise[5];
    assign save_rise = rise[6];
    assign enc_inc = enc_invert ? rise[8] : rise[7];
    assign enc_dec = enc_invert ? rise[7] : rise[8];
    assign cv_inc = rise[9];
    assign cv_dec = rise[10];
    assign clk_rise = rise[11];
    assign rst_rise = rise[12];
    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    logic [8:0] glide_q;
    logic [6:0] succ_q;
    logic [6:0] loops_q;
    logic [6:0] loop_cnt_q;
    logic [15:0] glide_en_q;
    logic [3:0] scale_q;
    logic [4:0] pitch_sw_q;
    logic [98:0] patch_full_q;
    logic mode_cal_q;
    logic rst_mutate_q;
    logic [3:0] bright_q;
    logic numeric_q;
    logic invert_q;
    logic [7:0] cal_p_q [8];
    logic [7:0] cal_c_q [8];
    logic [7:0] nv_p_q [8];
    logic [7:0] nv_c_q [8];
    logic [2:0] oct_q;
    logic cal_force_q;
    logic running_q;
    logic [3:0] step_q;
    logic wr;
    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    // Pitch edit from software or knob; knob skips out-of-scale notes
    logic [11:0] mask;
    logic [4:0] knob_next;
    always_comb begin
        case (scale_q)
            4'h1: mask = 12'hAB5;
            4'h2: mask = 12'h5AD;
            4'h3: mask = 12'h295;
            4'h4: mask = 12'h4A9;
            4'h5: mask = 12'h4E9;
            4'h6: mask = 12'h4ED;
            4'h7: mask = 12'h5AB;
            4'h8: mask = 12'h6AD;
            4'h9: mask = 12'h555;
            default: mask = seq_ctrl_pkg::CHROMATIC;
        endcase
    end
    function automatic logic [4:0] snap(input logic [4:0] p,
                                        input logic [11:0] m);
        logic [4:0] r;
        logic [3:0] k;
        r = p;
        k = 4'(p % 5'd12);
        for (int i = 0; i < 12; i++) begin
            if (!m[k] && k != 4'd0) begin
                k = k - 4'd1;
                r = r - 5'd1;
            end
        end
        return r;
    endfunction
    always_comb begin
        knob_next = pitch_sw_q;
        if (enc_inc && pitch_sw_q < 5'd24) begin
            knob_next = pitch_sw_q + 5'd1;
            for (int i = 0; i < 11; i++) begin
                if (!mask[4'(knob_next % 5'd12)] && knob_next < 5'd24) begin
                    knob_next = knob_next + 5'd1;
                end
            end
        end else if (enc_dec && pitch_sw_q > 5'd0) begin
            knob_next = snap(pitch_sw_q - 5'd1, mask);
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            glide_q <= seq_ctrl_pkg::GLIDE_RST;
            succ_q <= seq_ctrl_pkg::CHAIN_RST;
            loops_q <= seq_ctrl_pkg::CHAIN_RST;
            glide_en_q <= 16'h0000;
            scale_q <= 4'h0;
            pitch_sw_q <= 5'h00;
            patch_full_q <= '0;
        end else begin
            if (!mode_cal_q && !shift_lvl) begin
                pitch_sw_q <= knob_next;
            end
            if (!mode_cal_q && shift_lvl && chain_sel_loops) begin
                if (enc_inc && loops_q < seq_ctrl_pkg::CHAIN_MAX) begin
                    loops_q <= loops_q + 7'd1;
                end else if (enc_dec && loops_q != 7'd0) begin
                    loops_q <= loops_q - 7'd1;
                end
            end else if (!mode_cal_q && shift_lvl) begin
                if (enc_inc && succ_q < seq_ctrl_pkg::CHAIN_MAX) begin
                    succ_q <= succ_q + 7'd1;
                end else if (enc_dec && succ_q != 7'd0) begin
                    succ_q <= succ_q - 7'd1;
                end
            end
            if (wr) begin
                unique case (paddr)
                    seq_ctrl_pkg::GLIDE_OFS:
                        if (pwdata[8:0] <= seq_ctrl_pkg::GLIDE_MAX) begin
                            glide_q <= pwdata[8:0];
                        end
                    seq_ctrl_pkg::CHAIN_OFS: begin
                        if (pwdata[6:0] <= seq_ctrl_pkg::CHAIN_MAX) begin
                            succ_q <= pwdata[6:0];
                        end
                        if (pwdata[14:8] <= seq_ctrl_pkg::CHAIN_MAX) begin
                            loops_q <= pwdata[14:8];
                        end
                    end
                    seq_ctrl_pkg::STEP_OFS: glide_en_q <= pwdata[15:0];
                    seq_ctrl_pkg::PITCH_OFS: begin
                        scale_q <= pwdata[11:8];
                        if (pwdata[4:0] <= 5'd24) begin
                            pitch_sw_q <= pwdata[4:0];
                        end
                    end
                    seq_ctrl_pkg::PATCH_OFS:
                        patch_full_q[pwdata[6:0] - 7'd1] <= pwdata[8];
                    default: ;
                endcase
            end
        end
    end
    // ------------------------------------------------------------------
    // Sequencer, loop counter and song chaining
    // ------------------------------------------------------------------
    logic wrap;
    logic succ_ok;
    logic chain_go;
    logic restart;
    assign restart = (shift_lvl && play_rise)
                     || (rst_rise && !rst_mutate_q);
    assign wrap = running_q && clk_rise && step_q == seq_ctrl_pkg::LAST_STEP;
    assign succ_ok = succ_q != 7'd0 && succ_q <= seq_ctrl_pkg::PATCH_CNT
                     && patch_full_q[succ_q - 7'd1];
    assign chain_go = wrap && loops_q != 7'd0 && succ_ok
                      && loop_cnt_q + 7'd1 >= loops_q;
    logic sel_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            step_q <= 4'h0;
            running_q <= 1'b0;
            loop_cnt_q <= 7'h00;
            load_req <= 1'b0;
            load_patch <= 7'h00;
            sel_q <= 1'b0;
        end else begin
            load_req <= 1'b0;
            if (!mode_cal_q && shift_lvl && step_rise[15]) begin
                sel_q <= ~sel_q;
            end
            if (restart) begin
                step_q <= 4'h0;
                loop_cnt_q <= 7'h00;
                running_q <= 1'b0;
            end else begin
                if (play_rise && !shift_lvl) begin
                    running_q <= ~running_q;
                end
                if (clk_rise) begin
                    running_q <= 1'b1;
                end
                if (running_q && clk_rise) begin
                    step_q <= step_q + 4'd1;
                end
                if (chain_go) begin
                    loop_cnt_q <= 7'h00;
                    load_req <= 1'b1;
                    load_patch <= succ_q;
                end else if (wrap) begin
                    loop_cnt_q <= loop_cnt_q + 7'd1;
                end
                if (shift_lvl && load_rise && succ_ok) begin
                    load_req <= 1'b1;
                    load_patch <= succ_q;
                end
            end
        end
    end
    assign chain_sel_loops = sel_q;
    assign step_idx = step_q;
    // ------------------------------------------------------------------
    // Glide ramp
    // ------------------------------------------------------------------
    logic [15:0] period_q;
    logic [15:0] per_cnt_q;
    logic [15:0] target;
    logic [15:0] level_q;
    logic [15:0] ramp_left_q;
    logic [15:0] step_sz_q;
    logic [24:0] glide_cyc;
    // Quantized note from stored pitch, never written back
    assign target = 16'(snap(pitch_sw_q, mask)) * 16'd42;
    assign glide_cyc = 25'(period_q) * 25'(glide_q) / 25'(seq_ctrl_pkg::PCT_FULL);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            period_q <= 16'h0001;
            per_cnt_q <= 16'h0000;
            level_q <= 16'h0000;
            ramp_left_q <= 16'h0000;
            step_sz_q <= 16'h0000;
        end else begin
            per_cnt_q <= (clk_rise) ? 16'h0000 : per_cnt_q + 16'd1;
            if (clk_rise) begin
                period_q <= per_cnt_q;
            end
            if (clk_rise && glide_en_q[step_q + 4'd1] && glide_q != 9'd0) begin
                // Ramp may outlast the step when above full length
                ramp_left_q <= glide_cyc[15:0];
                step_sz_q <= 16'(((target > level_q) ? target - level_q
                             : level_q - target)
                             / ((glide_cyc[15:0] == 16'h0) ? 16'h1
                             : glide_cyc[15:0])) + 16'd1;
            end else if (ramp_left_q != 16'h0) begin
                ramp_left_q <= ramp_left_q - 16'd1;
                if (level_q + step_sz_q < target) begin
                    level_q <= level_q + step_sz_q;
                end else if (level_q > target + step_sz_q) begin
                    level_q <= level_q - step_sz_q;
                end else begin
                    level_q <= target;
                end
            end else if (clk_rise || ramp_left_q == 16'h0) begin
                level_q <= target;
            end
        end
    end
    // ------------------------------------------------------------------
    // Calibration mode and settings
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_cal_q <= 1'b0;
            oct_q <= 3'h0;
            cal_store <= 1'b0;
            rst_mutate_q <= 1'b0;
            bright_q <= seq_ctrl_pkg::BRIGHT_RST;
            invert_q <= 1'b0;
            numeric_q <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                cal_p_q[i] <= 8'h80;
                cal_c_q[i] <= 8'h80;
                nv_p_q[i] <= 8'h80;
                nv_c_q[i] <= 8'h80;
            end
        end else begin
            cal_store <= 1'b0;
            if (!mode_cal_q && shift_lvl && step_rise[13]) begin
                mode_cal_q <= 1'b1;
            end else if (mode_cal_q) begin
                for (int i = 0; i < 8; i++) begin
                    if (step_rise[i]) begin
                        oct_q <= 3'(i);
                    end
                end
                // Button 9 held turns the encoder into a brightness control
                if (!st2_q[8]) begin
                    if (enc_inc) cal_p_q[oct_q] <= cal_p_q[oct_q] + 8'd1;
                    if (enc_dec) cal_p_q[oct_q] <= cal_p_q[oct_q] - 8'd1;
                end else begin
                    if (enc_inc && bright_q != 4'hF) bright_q <= bright_q + 4'd1;
                    if (enc_dec && bright_q != 4'h0) bright_q <= bright_q - 4'd1;
                end
                if (cv_inc) cal_c_q[oct_q] <= cal_c_q[oct_q] + 8'd1;
                if (cv_dec) cal_c_q[oct_q] <= cal_c_q[oct_q] - 8'd1;
                if (step_rise[10]) rst_mutate_q <= ~rst_mutate_q;
                if (step_rise[12]) invert_q <= ~invert_q;
                if (step_rise[14]) numeric_q <= 1'b0;
                if (step_rise[15]) numeric_q <= 1'b1;
                if (save_rise) begin
                    nv_p_q <= cal_p_q;
                    nv_c_q <= cal_c_q;
                    cal_store <= 1'b1;
                end else if (shift_rise) begin
                    cal_p_q <= nv_p_q;
                    cal_c_q <= nv_c_q;
                    mode_cal_q <= 1'b0;
                end
            end
        end
    end
    assign brightness = bright_q;
    assign enc_invert = invert_q;
    assign numeric_disp = numeric_q;
    assign mutate_trig = rst_mutate_q & s2_q[12];
    // Outputs: forced octave level plus correction in calibration mode
    logic [15:0] oct_lvl;
    assign oct_lvl = 16'(oct_q + 3'd0) * seq_ctrl_pkg::UNITS_PER_VOLT
                     + seq_ctrl_pkg::UNITS_PER_VOLT;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pitch_out <= 16'h0000;
            cv_out <= 16'h0000;
        end else if (mode_cal_q) begin
            pitch_out <= oct_lvl + 16'(cal_p_q[oct_q]) - 16'h0080;
            cv_out <= oct_lvl + 16'(cal_c_q[oct_q]) - 16'h0080;
        end else begin
            pitch_out <= level_q;
            cv_out <= level_q;
        end
    end
    // ------------------------------------------------------------------
    // Register read back
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                seq_ctrl_pkg::CTRL_OFS:
                    prdata <= {30'h0, running_q, mode_cal_q};
                seq_ctrl_pkg::GLIDE_OFS: prdata <= {23'h0, glide_q};
                seq_ctrl_pkg::CHAIN_OFS:
                    prdata <= {17'h0, loops_q, 1'b0, succ_q};
                seq_ctrl_pkg::STEP_OFS: prdata <= {16'h0, glide_en_q};
                seq_ctrl_pkg::PITCH_OFS:
                    prdata <= {20'h0, scale_q, 3'h0, pitch_sw_q};
                seq_ctrl_pkg::STATUS_OFS:
                    prdata <= {17'h0, loop_cnt_q, 4'h0, step_q};
                seq_ctrl_pkg::CAL_OFS:
                    prdata <= {13'h0, oct_q, cal_c_q[oct_q], cal_p_q[oct_q]};
                seq_ctrl_pkg::SET_OFS:
                    prdata <= {24'h0, chain_sel_loops, numeric_q, invert_q,
                               rst_mutate_q, bright_q};
                seq_ctrl_pkg::OUT_OFS: prdata <= {cv_out, pitch_out};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ---- seq_ctrl_assertions.sv ----
// Checker: port-level properties of the sequencer control
`timescale 1ns/1ps
module seq_ctrl_checker (
    // Clock and bus
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pready,
    input wire logic pslverr,
    // Panel
    input wire logic shift_btn,
    input wire logic save_btn,
    input wire logic [15:0] step_btn,
    // Outputs
    input wire logic load_req,
    input wire logic [6:0] load_patch,
    input wire logic cal_store,
    input wire logic [3:0] brightness,
    input wire logic enc_invert,
    input wire logic numeric_disp,
    input wire logic chain_sel_loops
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_rst_vals;
        $fell(sys_rst) |-> brightness == 4'hF && !enc_invert;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("bad reset value");
    property p_load_pulse;
        load_req |=> !load_req;
    endproperty
    a_load_pulse: assert property (p_load_pulse) else $error("long load");
    property p_load_patch;
        load_req |-> load_patch != 7'h00 && load_patch <= 7'h63;
    endproperty
    a_load_patch: assert property (p_load_patch) else $error("bad patch");
    property p_store_pulse;
        cal_store |=> !cal_store;
    endproperty
    a_store_pulse: assert property (p_store_pulse) else $error("long store");
    property p_store_src;
        cal_store |-> $past(save_btn, 3);
    endproperty
    a_store_src: assert property (p_store_src) else $error("stray store");
    // Settings only move after the button passed the synchroniser
    property p_inv_src;
        $changed(enc_invert) |-> ($past(step_btn, 3) & 16'h1000) != 16'h0000;
    endproperty
    a_inv_src: assert property (p_inv_src) else $error("stray invert");
    property p_num_src;
        $changed(numeric_disp) |-> ($past(step_btn, 3) & 16'hC000) != 16'h0000;
    endproperty
    a_num_src: assert property (p_num_src) else $error("stray display");
    property p_sel_src;
        $changed(chain_sel_loops) |-> $past(shift_btn, 3)
            ##0 ($past(step_btn, 3) & 16'h8000) != 16'h0000;
    endproperty
    a_sel_src: assert property (p_sel_src) else $error("stray select");
endmodule
bind seq_ctrl seq_ctrl_checker i_chk (.*);

// ---- panel_model.sv ----
// Partner model: front-panel buttons, encoder, CV knob and jacks
`timescale 1ns/1ps
module panel_model (
    // Clock
    input wire logic clk,
    // Buttons
    output logic shift_btn,
    output logic play_btn,
    output logic load_btn,
    output logic save_btn,
    output logic [15:0] step_btn,
    // Knobs and jacks
    output logic enc_up,
    output logic enc_dn,
    output logic cv_up,
    output logic cv_dn,
    output logic clk_in,
    output logic reset_in
);
    // ------------------------------------------------------------
    // Human-speed actions, far slower than the synchroniser
    // ------------------------------------------------------------
    initial begin
        {shift_btn, play_btn, load_btn, save_btn, step_btn} = '0;
        {enc_up, enc_dn, cv_up, cv_dn, clk_in, reset_in} = '0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Bit 16 play, 17 load, 18 save, below them the step buttons
    task automatic press(input logic sh, input logic [18:0] b);
        hold(1);
        shift_btn <= sh;
        hold(4);
        {save_btn, load_btn, play_btn, step_btn} <= b;
        hold(8);
        {save_btn, load_btn, play_btn, step_btn} <= '0;
        hold(4);
        shift_btn <= 1'b0;
        hold(8);
    endtask
    // Select bit 0 encoder, 1 CV knob, 2 clock jack
    task automatic tick(input logic [2:0] sel, input int n);
        repeat (n) begin
            hold(1);
            {clk_in, cv_up, enc_up} <= sel;
            hold(4);
            {clk_in, cv_up, enc_up} <= 3'b000;
            hold(3);
        end
        hold(6);
    endtask
endmodule

// ---- seq_ctrl_tb.sv ----
// Testbench: sequencer control over APB with the panel model
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    err_total++; \
    $display("unexpected at %0t got %h exp %h", $time, (a), (e)); end end
module seq_ctrl_tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, load_req, cal_store;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic shift_btn, play_btn, load_btn, save_btn, enc_up, enc_dn;
    logic cv_up, cv_dn, clk_in, reset_in, mutate_trig, enc_invert;
    logic numeric_disp, chain_sel_loops;
    logic [15:0] step_btn, pitch_out, cv_out;
    logic [3:0] step_idx, brightness;
    logic [6:0] load_patch, last_patch;
    int err_total = 0, samples_checked = 0, n_load = 0, n_store = 0;
    typedef struct {logic [11:0] a; logic [31:0] w, m, e;} row_t;
    row_t rows[8] = '{
        '{seq_ctrl_pkg::GLIDE_OFS, 32'h0000_0190, 32'h0000_01FF, 32'h0000_0190},
        '{seq_ctrl_pkg::GLIDE_OFS, 32'h0000_0191, 32'h0000_01FF, 32'h0000_0190},
        '{seq_ctrl_pkg::GLIDE_OFS, 32'h0000_0000, 32'h0000_01FF, 32'h0000_0000},
        '{seq_ctrl_pkg::CHAIN_OFS, 32'h0000_0305, 32'h0000_7F7F, 32'h0000_0305},
        '{seq_ctrl_pkg::CHAIN_OFS, 32'h0000_0364, 32'h0000_7F7F, 32'h0000_0305},
        '{seq_ctrl_pkg::CHAIN_OFS, 32'h0000_6363, 32'h0000_7F7F, 32'h0000_6363},
        '{seq_ctrl_pkg::CHAIN_OFS, 32'h0000_0000, 32'h0000_7F7F, 32'h0000_0000},
        '{12'h03C, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000}};
    seq_ctrl i_dut (.*);
    panel_model i_panel (.*);
    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (load_req === 1'b1) begin
            n_load++;
            last_patch = load_patch;
        end
        if (cal_store === 1'b1) n_store++;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) err_total++;
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask
    // Restart, then feed clock pulses and count successor loads
    task automatic chain_run(input logic [31:0] cfg, input int n,
                             input int exp);
        int n0;
        apb(1'b1, seq_ctrl_pkg::CHAIN_OFS, cfg);
        i_panel.press(1'b1, 19'h1_0000);
        n0 = n_load;
        i_panel.tick(3'b100, n);
        `CHK(n_load - n0, exp)
    endtask
    initial begin
        #1_000_000;
        err_total++;
        print_verdict();
    end
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        int k;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(brightness, 4'hF)
        apb(1'b0, seq_ctrl_pkg::CHAIN_OFS, 32'h0000_0000);
        `CHK(rd[14:0], 15'h0000)
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, 32'h0000_0000);
            `CHK(rd & rows[i].m, rows[i].e)
        end
        i_panel.press(1'b1, 19'h0_8000);
        `CHK(chain_sel_loops, 1'b1)
        i_panel.press(1'b1, 19'h0_8000);
        `CHK(chain_sel_loops, 1'b0)
        apb(1'b1, seq_ctrl_pkg::PATCH_OFS, 32'h0000_0105);
        chain_run(32'h0000_0105, 17, 1);
        `CHK(last_patch, 7'h05)
        `CHK(step_idx, 4'h0)
        chain_run(32'h0000_0005, 40, 0);
        chain_run(32'h0000_0107, 17, 0);
        apb(1'b1, seq_ctrl_pkg::CHAIN_OFS, 32'h0000_0005);
        k = n_load;
        i_panel.press(1'b1, 19'h2_0000);
        `CHK(n_load - k, 1)
        i_panel.press(1'b1, 19'h0_2000);
        apb(1'b0, seq_ctrl_pkg::CTRL_OFS, 32'h0000_0000);
        `CHK(rd[0], 1'b1)
        for (int n = 1; n <= 8; n++) begin
            i_panel.press(1'b0, 19'(1 << (n - 1)));
            `CHK(pitch_out, 16'(n * 500))
        end
        i_panel.tick(3'b001, 3);
        `CHK(pitch_out, 16'h0FA3)
        i_panel.tick(3'b010, 2);
        `CHK(cv_out, 16'h0FA2)
        i_panel.press(1'b0, 19'h0_1000);
        `CHK(enc_invert, 1'b1)
        i_panel.press(1'b0, 19'h0_8000);
        `CHK(numeric_disp, 1'b1)
        i_panel.press(1'b0, 19'h0_4000);
        `CHK(numeric_disp, 1'b0)
        k = n_store;
        i_panel.press(1'b0, 19'h4_0000);
        `CHK(n_store - k, 1)
        i_panel.press(1'b1, 19'h0_0000);
        apb(1'b0, seq_ctrl_pkg::CTRL_OFS, 32'h0000_0000);
        `CHK(rd[0], 1'b0)
        print_verdict();
    end
endmodule
